// file: inc/hls_consts.svh
`ifndef HLS_CONSTS_SVH
`define HLS_CONSTS_SVH
// timing
`define HLS_CLK_NS 10
`define HLS_MS_NS 1000000
// sector geometry
`define HLS_CKS_IDX 9'd511
`define HLS_REV 16'h0010
`define HLS_THR_BASE 9'd2
`define HLS_THR_END 9'd362
`define HLS_ENT_BYTES 9'd12
`define HLS_EL_VER 8'h01
`define HLS_EL_REC 90
`define HLS_EL_NUM 5
`define HLS_EL_END 9'd452
`define HLS_EL_CNT_OFF 9'h1c4
`define HLS_EL_SNAP_END 8'h3c
`define HLS_EL_SNAP 8'd12
`define HLS_EL_CMD_OFF 8'd7
`define HLS_EL_STATE_OFF 9'h57
`define HLS_EL_HRS_OFF 9'h58
`define HLS_ST_DESC 24
`define HLS_ST_NUM 21
`define HLS_ST_END 9'd506
`define HLS_ST_PTR_OFF 9'h1fc
`define HLS_ST_REV 16'h0001
// revision byte halves, low byte sent first
`define HLS_REV_LO 8'h10
`define HLS_REV_HI 8'h00
`define HLS_ST_REV_LO 8'h01
`define HLS_ST_REV_HI 8'h00
// task file answers and command key
`define HLS_STS_OK 8'h50
`define HLS_STS_DRQ 8'h58
`define HLS_STS_ERR 8'h51
`define HLS_ERR_ABRT 8'h04
`define HLS_ERR_RDF 8'h40
`define HLS_ERR_WRF 8'h01
`define HLS_KEY_LO 8'h4f
`define HLS_KEY_HI 8'hc2
// subcommands, log selectors and capability bit
`define HLS_SC_RD_THR 8'hd1
`define HLS_SC_SAVE 8'hd3
`define HLS_SC_RD_LOG 8'hd5
`define HLS_SC_EN 8'hd8
`define HLS_SC_DIS 8'hd9
`define HLS_LOG_EL 8'h01
`define HLS_LOG_ST 8'h06
`define HLS_CAP_ELOG 8'h01
// register byte offsets
`define HLS_R_TASK 8'h00
`define HLS_R_CMD 8'h04
`define HLS_R_DATA 8'h08
`define HLS_R_FAULT 8'h0c
`define HLS_R_LOGWR 8'h10
`define HLS_R_COMMIT 8'h14
`define HLS_R_META 8'h18
`define HLS_R_HOURS 8'h1c
`define HLS_R_INFO 8'h20
`define HLS_R_LOGST 8'h24
`endif

// file: inc/hls_pkg.sv
package hls_pkg;
   typedef logic [7:0] hls_byte_t;
   typedef enum logic [1:0] {
      HLS_IDLE = 2'b01,
      HLS_STREAM = 2'b10
   } hls_state_e;
   typedef enum logic [2:0] {
      HLS_SEC_THR = 3'b001,
      HLS_SEC_EL = 3'b010,
      HLS_SEC_ST = 3'b100
   } hls_sec_e;
endpackage

// file: inc/hls_cks_if.sv
`timescale 1ns/1ps
interface hls_cks_if;
   logic clr;
   logic vld;
   logic [7:0] dat;
   logic [7:0] sum;
   modport src (output clr, output vld, output dat, input sum);
   modport acc (input clr, input vld, input dat, output sum);
endinterface

// file: core/hls_cksum.sv
`timescale 1ns/1ps
module hls_cksum
   import hls_pkg::*;
(
   // clock and reset
   input wire logic clock_i,
   input wire logic arst_n_i,
   // byte stream
   hls_cks_if.acc cks
);
   hls_byte_t acc_ff;

   // running modulo-256 sum of the bytes sent so far
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         acc_ff <= 8'h00;
      end else if (cks.clr) begin
         acc_ff <= 8'h00;
      end else if (cks.vld) begin
         acc_ff <= acc_ff + cks.dat;
      end
   end

   // two's complement so the whole sector sums to zero
   assign cks.sum = 8'h00 - acc_ff;
endmodule

// file: core/hls_thr_rom.sv
`timescale 1ns/1ps
`include "hls_consts.svh"
module hls_thr_rom
   import hls_pkg::*;
#(
   parameter logic [239:0] ATTR_IDS =
      240'h00000000000000000000000000c7c6c5c4c2c1c00c0a0908070504030201,
   parameter logic [239:0] THRESH = {30{8'h10}}
) (
   // byte index in, byte out
   input wire logic [8:0] idx_i,
   output hls_byte_t byte_o
);
   logic [8:0] rel;
   logic [4:0] ent;
   logic [3:0] pos;

   // fixed table; no write path exists, thresholds are build constants
   always_comb begin
      rel = idx_i - `HLS_THR_BASE;
      ent = 5'(rel / `HLS_ENT_BYTES);
      pos = 4'(rel % `HLS_ENT_BYTES);
      byte_o = 8'h00;
      if (idx_i == 9'd0) begin
         byte_o = `HLS_REV_LO;
      end else if (idx_i == 9'd1) begin
         byte_o = `HLS_REV_HI;
      end else if (idx_i < `HLS_THR_END) begin
         if (pos == 4'h0) begin
            byte_o = ATTR_IDS[8*ent+:8];
         end else if (pos == 4'h1 && ATTR_IDS[8*ent+:8] != 8'h00) begin
            byte_o = THRESH[8*ent+:8];
         end
      end
   end
endmodule

// file: core/hls_sector_top.sv
// Added by the designer: the address map and the Wishbone register port.
`timescale 1ns/1ps
`include "hls_consts.svh"
// Overview of operation
// R1: final byte makes sector sum zero
// R2: threshold sector: revision, thirty entries, zeros
// R3: threshold order matches attribute order
// R4: entry is id, threshold, ten zeros
// R5: thresholds fixed, host cannot change them
// R6: multibyte fields stored low byte first
// R7: error log: version, pointer, records, count
// R8: error log version reads one
// R9: error pointer names newest record, one-five
// R10: error count increments, saturates at maximum
// R11: record is five commands then error
// R12: command snapshot: registers plus millisecond stamp
// R13: error snapshot: registers, state, hours
// R14: state low nibble encodes device condition
// R15: self-test descriptors every 24 bytes
// R16: 21 descriptors, oldest overwritten
// R17: self-test pointer zero when empty, else newest
// R18: bad key, subcommand, disabled state abort
// R19: sector read or write failure codes
// R20: checkpoint byte and completion minutes supplied
// R21: capability bit0 marks error logging
// R22: host reads each sector whole
// R23: checksum computed while streaming out
module hls_sector_top
   import hls_pkg::*;
#(
   parameter int MS_CYCLES = `HLS_MS_NS / `HLS_CLK_NS,
   parameter logic [7:0] SHORT_MIN = 8'h02,
   parameter logic [7:0] EXT_MIN = 8'h20
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic arst_n_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // task file view
   output logic [7:0] ata_status_o,
   output logic [7:0] ata_error_o,
   output logic drq_o
);
   localparam int EL_BYTES = `HLS_EL_REC * `HLS_EL_NUM;
   localparam int ST_BYTES = `HLS_ST_DESC * `HLS_ST_NUM;

   logic ack_ff;
   logic take;
   logic wr;
   logic rd;
   logic data_take;
   logic [31:0] task_ff;
   logic [31:0] meta_ff;
   logic [15:0] hours_ff;
   logic [1:0] fault_ff;
   logic en_ff;
   hls_byte_t status_ff;
   hls_byte_t err_ff;
   hls_state_e state_ff;
   hls_sec_e sec_ff;
   logic [8:0] idx_ff;
   logic [2:0] el_ptr_ff;
   logic [15:0] el_cnt_ff;
   logic [4:0] st_ptr_ff;
   logic [31:0] ms_div_ff;
   logic [31:0] ms_ff;
   logic [31:0] rdata_ff;
   hls_byte_t el_mem [0:EL_BYTES-1];
   hls_byte_t st_mem [0:ST_BYTES-1];
   hls_byte_t thr_byte;
   hls_byte_t sec_byte;
   hls_byte_t out_byte;
   hls_byte_t c_sts;
   hls_byte_t c_err;
   logic c_en;
   logic c_go;
   hls_sec_e c_sec;
   logic key_ok;
   logic [2:0] el_next;
   logic [4:0] st_next;
   logic [8:0] el_base;
   logic [8:0] st_base;
   logic [8:0] rel;
   logic [7:0] lw_off;
   hls_cks_if cks ();

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
      for (int i = 0; i < 4; i++) begin
         merge[8*i+:8] = s[i] ? n[8*i+:8] : o[8*i+:8];
      end
   endfunction

   function automatic hls_byte_t le_byte(input logic [31:0] w, input logic [1:0] k);
      le_byte = w[8*k+:8];
   endfunction

   function automatic logic [4:0] ring_next(input logic [4:0] p, input logic [4:0] top);
      ring_next = (p >= top) ? 5'd1 : 5'(p + 5'd1);
   endfunction

   // one-cycle classic answer, dropped in the cycle after it
   assign take = wb_cyc_i & wb_stb_i & ~ack_ff;
   assign wr = take & wb_we_i;
   assign rd = take & ~wb_we_i;
   assign data_take = rd && wb_adr_i == `HLS_R_DATA && state_ff == HLS_STREAM;
   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rdata_ff;
   assign ata_status_o = status_ff;
   assign ata_error_o = err_ff;
   assign drq_o = (state_ff == HLS_STREAM);

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= take;
      end
   end

   // ring slots for the next record; commit makes them current
   assign el_next = 3'(ring_next({2'b00, el_ptr_ff}, 5'd5));
   assign st_next = ring_next(st_ptr_ff, 5'd21);
   assign el_base = 9'(9'(el_next - 3'd1) * 9'd90);
   assign st_base = 9'(9'(st_next - 5'd1) * 9'd24);
   assign lw_off = wb_dat_i[15:8];
   assign rel = idx_ff - 9'd2;
   assign key_ok = task_ff[23:16] == `HLS_KEY_LO && task_ff[31:24] == `HLS_KEY_HI;

   // command evaluation; enable is the only subcommand allowed while disabled
   always_comb begin
      c_sts = `HLS_STS_OK;
      c_err = 8'h00;
      c_en = en_ff;
      c_go = 1'b0;
      c_sec = HLS_SEC_THR;
      if (!key_ok) begin
         c_sts = `HLS_STS_ERR; // [R18]
         c_err = `HLS_ERR_ABRT;
      end else if (task_ff[7:0] == `HLS_SC_EN) begin
         c_en = 1'b1;
      end else if (!en_ff) begin
         c_sts = `HLS_STS_ERR; // [R18]
         c_err = `HLS_ERR_ABRT;
      end else begin
         unique case (task_ff[7:0])
            `HLS_SC_DIS: c_en = 1'b0;
            `HLS_SC_RD_THR: begin
               if (fault_ff[0]) begin
                  c_sts = `HLS_STS_ERR; // [R19]
                  c_err = `HLS_ERR_RDF;
               end else begin
                  c_go = 1'b1;
               end
            end
            `HLS_SC_SAVE: begin
               if (fault_ff[1]) begin
                  c_sts = `HLS_STS_ERR; // [R19]
                  c_err = `HLS_ERR_WRF;
               end
            end
            `HLS_SC_RD_LOG: begin
               if (task_ff[15:8] == `HLS_LOG_EL) begin
                  c_go = 1'b1;
                  c_sec = HLS_SEC_EL;
               end else if (task_ff[15:8] == `HLS_LOG_ST) begin
                  c_go = 1'b1;
                  c_sec = HLS_SEC_ST;
               end else begin
                  c_sts = `HLS_STS_ERR; // [R18]
                  c_err = `HLS_ERR_ABRT;
               end
            end
            default: begin
               c_sts = `HLS_STS_ERR; // [R18]
               c_err = `HLS_ERR_ABRT;
            end
         endcase
      end
      if (c_go) begin
         c_sts = `HLS_STS_DRQ;
      end
   end

   // command results and sector streaming; a new read command restarts the stream
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         en_ff <= 1'b0;
         status_ff <= `HLS_STS_OK;
         err_ff <= 8'h00;
         state_ff <= HLS_IDLE;
         sec_ff <= HLS_SEC_THR;
         idx_ff <= 9'd0;
      end else if (wr && wb_adr_i == `HLS_R_CMD) begin
         en_ff <= c_en;
         status_ff <= c_sts;
         err_ff <= c_err;
         if (c_go) begin
            state_ff <= HLS_STREAM;
            sec_ff <= c_sec;
            idx_ff <= 9'd0;
         end
      end else if (data_take) begin
         idx_ff <= 9'(idx_ff + 9'd1);
         if (idx_ff == `HLS_CKS_IDX) begin
            state_ff <= HLS_IDLE; // [R22] all 512 bytes go out
            status_ff <= `HLS_STS_OK;
         end
      end
   end

   hls_thr_rom u_rom (
      .idx_i(idx_ff),
      .byte_o(thr_byte)
   ); // [R3] [R5]

   // byte at the stream index; multibyte fields low byte first
   always_comb begin
      sec_byte = 8'h00;
      unique case (sec_ff)
         HLS_SEC_THR: sec_byte = thr_byte; // [R2] [R4]
         HLS_SEC_EL: begin
            if (idx_ff == 9'd0) begin
               sec_byte = `HLS_EL_VER; // [R8]
            end else if (idx_ff == 9'd1) begin
               sec_byte = {5'h00, el_ptr_ff}; // [R7]
            end else if (idx_ff < `HLS_EL_END) begin
               sec_byte = el_mem[rel]; // [R11]
            end else if (idx_ff == `HLS_EL_CNT_OFF) begin
               sec_byte = el_cnt_ff[7:0]; // [R6]
            end else if (idx_ff == 9'(`HLS_EL_CNT_OFF + 9'd1)) begin
               sec_byte = el_cnt_ff[15:8];
            end
         end
         HLS_SEC_ST: begin
            if (idx_ff == 9'd0) begin
               sec_byte = `HLS_ST_REV_LO;
            end else if (idx_ff == 9'd1) begin
               sec_byte = `HLS_ST_REV_HI;
            end else if (idx_ff < `HLS_ST_END) begin
               sec_byte = st_mem[rel]; // [R15]
            end else if (idx_ff == `HLS_ST_PTR_OFF) begin
               sec_byte = {3'h0, st_ptr_ff};
            end
         end
         default: sec_byte = 8'h00;
      endcase
   end

   // checksum replaces the last byte so every sector is self-consistent
   assign out_byte = (idx_ff == `HLS_CKS_IDX) ? cks.sum : sec_byte; // [R1] [R23]
   assign cks.clr = wr && wb_adr_i == `HLS_R_CMD;
   assign cks.vld = data_take && idx_ff != `HLS_CKS_IDX; // [R23]
   assign cks.dat = sec_byte;

   hls_cksum u_cks (
      .clock_i(clock_i),
      .arst_n_i(arst_n_i),
      .cks(cks.acc)
   );

   // plain software registers, byte lanes honoured
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         task_ff <= 32'h00000000;
         meta_ff <= 32'h00000000;
         hours_ff <= 16'h0000;
         fault_ff <= 2'b00;
      end else if (wr) begin
         if (wb_adr_i == `HLS_R_TASK) task_ff <= merge(task_ff, wb_dat_i, wb_sel_i);
         if (wb_adr_i == `HLS_R_META) meta_ff <= merge(meta_ff, wb_dat_i, wb_sel_i);
         if (wb_adr_i == `HLS_R_HOURS && wb_sel_i[0]) hours_ff[7:0] <= wb_dat_i[7:0];
         if (wb_adr_i == `HLS_R_HOURS && wb_sel_i[1]) hours_ff[15:8] <= wb_dat_i[15:8];
         if (wb_adr_i == `HLS_R_FAULT && wb_sel_i[0]) fault_ff <= wb_dat_i[1:0];
      end
   end

   // millisecond count since reset for command snapshots
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ms_div_ff <= 32'h00000000;
         ms_ff <= 32'h00000000;
      end else if (ms_div_ff == 32'(MS_CYCLES - 1)) begin
         ms_div_ff <= 32'h00000000;
         ms_ff <= ms_ff + 32'h00000001;
      end else begin
         ms_div_ff <= ms_div_ff + 32'h00000001;
      end
   end

   // error record fill; writing a command byte stamps the time after it
   always_ff @(posedge clock_i) begin
      if (wr && wb_adr_i == `HLS_R_LOGWR && !wb_dat_i[16] && lw_off < 8'd90) begin
         el_mem[9'(el_base + 9'(lw_off))] <= wb_dat_i[7:0];
         if (lw_off < `HLS_EL_SNAP_END && (lw_off % `HLS_EL_SNAP) == `HLS_EL_CMD_OFF) begin
            for (int k = 0; k < 4; k++) begin
               el_mem[9'(el_base + 9'(lw_off) + 9'(k + 1))] <= le_byte(ms_ff, 2'(k)); // [R12]
            end
         end
      end
      if (wr && wb_adr_i == `HLS_R_COMMIT && wb_dat_i[0]) begin
         el_mem[9'(el_base + `HLS_EL_STATE_OFF)] <= {4'h0, meta_ff[27:24]}; // [R13] [R14]
         el_mem[9'(el_base + `HLS_EL_HRS_OFF)] <= hours_ff[7:0]; // [R6]
         el_mem[9'(el_base + `HLS_EL_HRS_OFF + 9'd1)] <= hours_ff[15:8];
      end
   end

   // self-test descriptor fill; commit stamps number, status, hours, checkpoint
   always_ff @(posedge clock_i) begin
      if (wr && wb_adr_i == `HLS_R_LOGWR && wb_dat_i[16] && lw_off < 8'd24) begin
         st_mem[9'(st_base + 9'(lw_off))] <= wb_dat_i[7:0];
      end
      if (wr && wb_adr_i == `HLS_R_COMMIT && wb_dat_i[1]) begin
         st_mem[st_base] <= meta_ff[7:0]; // [R15]
         st_mem[9'(st_base + 9'd1)] <= meta_ff[15:8];
         st_mem[9'(st_base + 9'd2)] <= hours_ff[7:0];
         st_mem[9'(st_base + 9'd3)] <= hours_ff[15:8];
         st_mem[9'(st_base + 9'd6)] <= meta_ff[23:16]; // [R20]
      end
   end

   // ring pointers and the saturating error count
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         el_ptr_ff <= 3'd0;
         el_cnt_ff <= 16'h0000;
         st_ptr_ff <= 5'd0; // [R17]
      end else if (wr && wb_adr_i == `HLS_R_COMMIT) begin
         if (wb_dat_i[0]) begin
            el_ptr_ff <= el_next; // [R9]
            if (el_cnt_ff != 16'hffff) el_cnt_ff <= el_cnt_ff + 16'h0001; // [R10]
         end
         if (wb_dat_i[1]) st_ptr_ff <= st_next; // [R16]
      end
   end

   // read data; the data port advances the stream as a side effect
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_ff <= 32'h00000000;
      end else if (rd) begin
         case (wb_adr_i)
            `HLS_R_TASK: rdata_ff <= task_ff;
            `HLS_R_CMD: rdata_ff <= {7'h00, en_ff, 8'h00, err_ff, status_ff};
            `HLS_R_DATA: rdata_ff <= data_take ? {24'h000000, out_byte} : 32'h00000000;
            `HLS_R_FAULT: rdata_ff <= {30'h00000000, fault_ff};
            `HLS_R_META: rdata_ff <= meta_ff;
            `HLS_R_HOURS: rdata_ff <= {16'h0000, hours_ff};
            `HLS_R_INFO: rdata_ff <= {8'h00, EXT_MIN, SHORT_MIN, `HLS_CAP_ELOG}; // [R20] [R21]
            `HLS_R_LOGST: rdata_ff <= {el_cnt_ff, 3'h0, st_ptr_ff, 5'h00, el_ptr_ff};
            default: rdata_ff <= 32'h00000000;
         endcase
      end
   end

   default clocking @(posedge clock_i); endclocking
   default disable iff (!arst_n_i);

   sequence cmd_wr_s;
      wr && wb_adr_i == `HLS_R_CMD;
   endsequence
   sequence thr_zero_s;
      data_take && sec_ff == HLS_SEC_THR && idx_ff >= 9'd2 && idx_ff != `HLS_CKS_IDX &&
         (idx_ff >= `HLS_THR_END || (rel % `HLS_ENT_BYTES) >= 9'd2);
   endsequence

   cks_last_a: assert property (data_take && idx_ff == `HLS_CKS_IDX |=> // [R1]
      wb_dat_o == {24'h000000, $past(cks.sum)}) else $error("checksum byte wrong");
   thr_rev_a: assert property (data_take && sec_ff == HLS_SEC_THR && idx_ff == 9'd0 |=> // [R2]
      wb_dat_o == 32'h00000010) else $error("threshold revision wrong");
   thr_zero_a: assert property (thr_zero_s |=> wb_dat_o == 32'h00000000) // [R4]
      else $error("threshold reserved byte not zero");
   el_ver_a: assert property (data_take && sec_ff == HLS_SEC_EL && idx_ff == 9'd0 |=> // [R8]
      wb_dat_o == 32'h00000001) else $error("error log version wrong");
   el_ptr_a: assert property (el_cnt_ff != 16'h0000 |-> // [R9]
      el_ptr_ff >= 3'd1 && el_ptr_ff <= 3'd5) else $error("error pointer out of range");
   el_sat_a: assert property (wr && wb_adr_i == `HLS_R_COMMIT && wb_dat_i[0] |=> // [R10]
      el_cnt_ff == (($past(el_cnt_ff) == 16'hffff) ?
      16'hffff : 16'($past(el_cnt_ff) + 16'h0001))) else $error("error count wrong");
   st_ring_a: assert property (wr && wb_adr_i == `HLS_R_COMMIT && wb_dat_i[1] && // [R16]
      st_ptr_ff == 5'd21 |=> st_ptr_ff == 5'd1) else $error("self-test ring wrong");
   st_ptr_a: assert property (st_ptr_ff <= 5'd21) // [R17]
      else $error("self-test pointer out of range");
   abort_key_a: assert property (cmd_wr_s ##0 !key_ok |=> // [R18]
      status_ff == `HLS_STS_ERR && err_ff == `HLS_ERR_ABRT ##1 status_ff == `HLS_STS_ERR)
      else $error("bad key not aborted");
   rd_fail_a: assert property (cmd_wr_s ##0 (key_ok && en_ff && fault_ff[0] && // [R19]
      task_ff[7:0] == `HLS_SC_RD_THR) |=> err_ff == `HLS_ERR_RDF && !drq_o)
      else $error("read failure not reported");
endmodule

// file: tb/hls_host_model.sv
`timescale 1ns/1ps
// host side of the link: a classic bus master, one cycle at a time
module hls_host_model (
   // clock
   input wire logic clock_i,
   // wishbone master
   output logic cyc_o,
   output logic stb_o,
   output logic we_o,
   output logic [7:0] adr_o,
   output logic [3:0] sel_o,
   output logic [31:0] dat_o,
   input wire logic [31:0] dat_i,
   input wire logic ack_i
);
   // idle bus from time zero
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o = 1'b0;
      adr_o = 8'h00;
      sel_o = 4'h0;
      dat_o = 32'h0;
   end
   // request held until ack is sampled; the bench watchdog bounds the wait
   task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= we;
      adr_o <= a;
      sel_o <= 4'hf;
      dat_o <= wd;
      @(posedge clock_i);
      while (ack_i !== 1'b1) @(posedge clock_i);
      rd = dat_i;
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      // idle gap so the slave sees the bus released
      @(posedge clock_i);
   endtask
endmodule

// file: tb/test_hls_sector_top.sv
`timescale 1ns/1ps
`include "hls_consts.svh"
module test_hls_sector_top;
   import hls_pkg::*;
   localparam logic [15:0] KEY = {`HLS_KEY_HI, `HLS_KEY_LO};
   localparam logic [15:0] REV = `HLS_REV;
   localparam logic [239:0] IDS = 240'hc7c6c5c4c2c1c00c0a0908070504030201;
   localparam logic [7:0] SMIN = 8'h03;
   localparam logic [7:0] EMIN = 8'h21;
   logic clock_i;
   logic arst_n_i;
   logic cyc, stb, we, ack, drq;
   logic [7:0] adr, sts, err;
   logic [3:0] sel;
   logic [31:0] wdat, rdat;
   logic [7:0] sec [512];
   int err_count = 0;
   int check_count = 0;

   // 100 MHz clock
   initial clock_i = 1'b0;
   always #5 clock_i = ~clock_i;

   hls_sector_top #(.MS_CYCLES(10), .SHORT_MIN(SMIN), .EXT_MIN(EMIN)) hls_sector_top_inst (
      .clock_i(clock_i), .arst_n_i(arst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .ata_status_o(sts), .ata_error_o(err), .drq_o(drq));
   hls_host_model hls_host_model_inst (
      .clock_i(clock_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
      .dat_o(wdat), .dat_i(rdat), .ack_i(ack));

   task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // bus helpers
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      hls_host_model_inst.xfer(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      hls_host_model_inst.xfer(1'b0, a, 32'h0, d);
   endtask
   task automatic cmd(input logic [7:0] f, input logic [7:0] s, input logic [15:0] k);
      wr(`HLS_R_TASK, {k, s, f});
      wr(`HLS_R_CMD, 32'h0);
   endtask
   task automatic ans(input logic [7:0] s, input logic [7:0] e);
      chk8("status", s, sts);
      chk8("error", e, err);
   endtask
   // whole-sector fetch, the only way the host reads a sector
   task automatic rd_sec();
      logic [31:0] d;
      logic [7:0] s;
      s = 8'h00;
      chk8("drq_open", 8'h01, {7'h0, drq});
      for (int i = 0; i < 512; i++) begin
         rd(`HLS_R_DATA, d);
         sec[i] = d[7:0];
         s = s + d[7:0];
      end
      chk8("sum", 8'h00, s);
      chk8("drq_done", 8'h00, {7'h0, drq});
      ans(`HLS_STS_OK, 8'h00);
   endtask

   // key, disabled state and bad subcommand
   task automatic t_abort();
      cmd(`HLS_SC_EN, 8'h00, 16'h0000);
      ans(`HLS_STS_ERR, `HLS_ERR_ABRT);
      cmd(`HLS_SC_RD_THR, 8'h00, KEY);
      ans(`HLS_STS_ERR, `HLS_ERR_ABRT);
      cmd(`HLS_SC_EN, 8'h00, KEY);
      ans(`HLS_STS_OK, 8'h00);
      cmd(8'h00, 8'h00, KEY);
      ans(`HLS_STS_ERR, `HLS_ERR_ABRT);
   endtask

   // threshold sector layout
   task automatic t_thr();
      logic [7:0] e;
      cmd(`HLS_SC_RD_THR, 8'h00, KEY);
      rd_sec();
      chk8("rev_lo", REV[7:0], sec[0]);
      chk8("rev_hi", REV[15:8], sec[1]);
      for (int k = 0; k < 30; k++) begin
         for (int b = 0; b < 12; b++) begin
            e = (b == 0) ? IDS[k*8 +: 8] : 8'h00;
            if (b == 1 && IDS[k*8 +: 8] != 8'h00) e = 8'h10;
            chk8("thr_entry", e, sec[2 + k*12 + b]);
         end
      end
      for (int i = 362; i < 511; i++) chk8("thr_pad", 8'h00, sec[i]);
   endtask

   // read and write failures
   task automatic t_fault();
      wr(`HLS_R_FAULT, 32'h1);
      cmd(`HLS_SC_RD_THR, 8'h00, KEY);
      ans(`HLS_STS_ERR, `HLS_ERR_RDF);
      wr(`HLS_R_FAULT, 32'h2);
      cmd(`HLS_SC_SAVE, 8'h00, KEY);
      ans(`HLS_STS_ERR, `HLS_ERR_WRF);
      wr(`HLS_R_FAULT, 32'h0);
      cmd(`HLS_SC_SAVE, 8'h00, KEY);
      ans(`HLS_STS_OK, 8'h00);
   endtask

   // six errors: the ring wraps once; last record keeps its ms stamp
   task automatic t_elog();
      logic [31:0] d;
      int c, b;
      for (int n = 1; n <= 6; n++) begin
         for (int o = 0; o < 90; o++)
            if (n < 6 || o < 8 || o > 11) wr(`HLS_R_LOGWR, {16'h0, o[7:0], o[7:0] ^ n[7:0]});
         wr(`HLS_R_META, {4'h0, 4'(n % 5), 24'h0});
         wr(`HLS_R_HOURS, {16'h0, 8'h01, n[7:0]});
         wr(`HLS_R_COMMIT, 32'h1);
         rd(`HLS_R_LOGST, d);
         chk8("el_ptr", 8'((n - 1) % 5 + 1), {5'h0, d[2:0]});
         chk32("el_cnt", 32'(n), {16'h0, d[31:16]});
      end
      cmd(`HLS_SC_RD_LOG, `HLS_LOG_EL, KEY);
      rd_sec();
      chk8("el_ver", `HLS_EL_VER, sec[0]);
      chk8("el_ptr_b", 8'h01, sec[1]);
      chk8("el_cnt_lo", 8'h06, sec['h1c4]);
      chk8("el_cnt_hi", 8'h00, sec['h1c5]);
      chk8("el_ms", 8'h01, {7'h0, {sec[13], sec[12], sec[11], sec[10]} != 0});
      for (int r = 1; r <= 5; r++) begin
         c = (r == 1) ? 6 : r;
         b = 2 + (r - 1) * 90;
         chk8("el_cmd", 8'h07 ^ 8'(c), sec[b + 7]);
         chk8("el_err", 8'h3d ^ 8'(c), sec[b + 'h3d]);
         chk8("el_state", 8'(c % 5), sec[b + 'h57]);
         chk8("el_hrs_lo", 8'(c), sec[b + 'h58]);
         chk8("el_hrs_hi", 8'h01, sec[b + 'h59]);
      end
   endtask

   // twenty-two self-tests: the oldest is overwritten
   task automatic t_stlog();
      logic [31:0] d;
      rd(`HLS_R_LOGST, d);
      chk8("st_empty", 8'h00, {3'h0, d[12:8]});
      for (int n = 1; n <= 22; n++) begin
         for (int o = 0; o < 24; o++) wr(`HLS_R_LOGWR, {15'h0, 1'b1, o[7:0], o[7:0] ^ n[7:0]});
         wr(`HLS_R_META, {8'h00, 8'(n + 'h40), 8'h20, n[7:0]});
         wr(`HLS_R_HOURS, {16'h0, 8'h02, n[7:0]});
         wr(`HLS_R_COMMIT, 32'h2);
         rd(`HLS_R_LOGST, d);
         chk8("st_ptr", 8'((n - 1) % 21 + 1), {3'h0, d[12:8]});
      end
      cmd(`HLS_SC_RD_LOG, `HLS_LOG_ST, KEY);
      rd_sec();
      chk8("st_num", 8'd22, sec[2]);
      chk8("st_exec", 8'h20, sec[3]);
      chk8("st_hrs_lo", 8'd22, sec[4]);
      chk8("st_hrs_hi", 8'h02, sec[5]);
      chk8("st_chkpt", 8'h56, sec[8]);
      chk8("st_lba", 8'h07 ^ 8'd22, sec[9]);
      chk8("st_num2", 8'd2, sec[26]);
      chk8("st_ptr_b", 8'h01, sec['h1fc]);
   endtask

   // capability word, unmapped address, disable
   task automatic t_misc();
      logic [31:0] d;
      rd(`HLS_R_INFO, d);
      chk32("info", {8'h00, EMIN, SMIN, `HLS_CAP_ELOG}, d);
      rd(8'hfc, d);
      chk32("unmapped", 32'h0, d);
      cmd(`HLS_SC_RD_LOG, 8'h02, KEY);
      ans(`HLS_STS_ERR, `HLS_ERR_ABRT);
      cmd(`HLS_SC_DIS, 8'h00, KEY);
      cmd(`HLS_SC_RD_LOG, `HLS_LOG_EL, KEY);
      ans(`HLS_STS_ERR, `HLS_ERR_ABRT);
   endtask

   // main sequence
   initial begin
      arst_n_i = 1'b0;
      repeat (12) @(posedge clock_i);
      arst_n_i <= 1'b1;
      @(posedge clock_i);
      ans(`HLS_STS_OK, 8'h00);
      t_abort();
      t_thr();
      t_fault();
      t_elog();
      t_stlog();
      t_misc();
      conclude();
   end

   // watchdog: the sequence needs well under 30000 cycles
   initial begin
      #600000;
      err_count++;
      conclude();
   end
endmodule
